//--- src/ubh_pkg.sv
// Functional notes
// - Break is start, twelve zeros, stop.
// - Data write with break request starts Break.
// - Hardware clears break request after Break stop.
// - Next byte buffered during Break, sent afterwards.
// - Shift-empty flag busy during Break, idle after.
// - Buffer-empty flag rises when data register empties.
// - Received Break gives framing error, data 00h.
// - Wake-on-break flags event, then receives next byte.
// - Clocked mode has no start or stop bits.
// - Clocked mode is half-duplex on one data line.
// - Clocked host transmits when receive enables clear.
// - Host drives clock pin, driver enabled automatically.
// - Exactly one clock cycle per data bit.
// - Data changes on leading edge, holds till next.
// - Polarity bit sets idle level and change edge.
// - Host transmit enables data and clock drivers.
// - Data waits while shifter busy, else moves at once.
// - Shift register is invisible to software.
// - Falling receive line is the wake event.
// - Rising receive line clears wake-on-break enable.
//
// Purpose: Constants for the break-capable serial port with clocked host mode.
// Assumes: 32-bit Avalon-MM register access, byte addresses.
// Notes: Offsets, field positions, reset values and counts live here.
package ubh_pkg;
  // Register byte offsets.
  localparam logic [4:0] UBH_OFF_CTRL = 5'h00;
  localparam logic [4:0] UBH_OFF_STATUS = 5'h04;
  localparam logic [4:0] UBH_OFF_TXDATA = 5'h08;
  localparam logic [4:0] UBH_OFF_RXDATA = 5'h0c;
  localparam logic [4:0] UBH_OFF_BAUD = 5'h10;
  // Control register field positions.
  localparam int UBH_CTRL_SERIAL_PORT_ENABLE = 0;
  localparam int UBH_CTRL_TRANSMIT_ENABLE = 1;
  localparam int UBH_CTRL_BREAK_SEND_REQUEST = 2;
  localparam int UBH_CTRL_SYNC = 3;
  localparam int UBH_CTRL_HOST = 4;
  localparam int UBH_CTRL_SINGLE_RECEIVE_ENABLE = 5;
  localparam int UBH_CTRL_CONTINUOUS_RECEIVE_ENABLE = 6;
  localparam int UBH_CTRL_POL = 7;
  localparam int UBH_CTRL_WAKE = 8;
  localparam int UBH_CTRL_ABD = 9;
  // Status register field positions.
  localparam int UBH_ST_SHIFT_EMPTY = 0;
  localparam int UBH_ST_BUF_EMPTY = 1;
  localparam int UBH_ST_RX_DONE = 2;
  localparam int UBH_ST_FRAME_ERR = 3;
  // Reset values.
  localparam logic [15:0] UBH_BAUD_RESET = 16'h0040;
  localparam logic [9:0] UBH_CTRL_RESET = 10'h000;
  // Bit counts: last bit index of a data character and of a Break.
  localparam logic [3:0] UBH_LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] UBH_LAST_BREAK_BIT = 4'hb;
  // Transmit and receive sequencer states, Gray coded along the path.
  typedef enum logic [1:0] {
    UBH_IDLE = 2'b00,
    UBH_START = 2'b01,
    UBH_DATA = 2'b11,
    UBH_STOP = 2'b10
  } ubh_seq_t;
endpackage

//--- src/ubh_serial.sv
// Purpose: Serial port transmit and receive with Break support and
//   clocked host transmit, behind an Avalon-MM register slave.
// Assumes: One clock domain at 10 MHz; pins are synchronised here.
// Notes: All state is one packed struct registered in a single process.
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ubh_serial
  import ubh_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_receive_or_data_pin,
  output logic o_receive_or_data_pin,
  output logic o_receive_or_data_pin_oe,
  output logic o_transmit_or_clock_pin,
  output logic o_transmit_or_clock_pin_oe
);

  // The whole state of the block.
  typedef struct packed {
    logic wait_rq;                  // Registered waitrequest.
    logic [31:0] rdata;             // Registered read data.
    logic [9:0] ctrl;               // Control register bits.
    logic [15:0] baud;              // Async bit time is baud plus one clocks.
    logic buf_full;                 // Transmit data register holds a byte.
    logic [7:0] buf_data;           // Transmit data register contents.
    ubh_seq_t tx_st;                // Transmit sequencer state.
    logic [7:0] shift;              // Hidden transmit shift register.
    logic [3:0] tx_bit;             // Bit index within the character.
    logic [3:0] tx_last;            // Last bit index for this character.
    logic tx_brk;                   // Current character is a Break.
    logic [15:0] tx_cnt;            // Transmit bit timer.
    logic phase;                    // Clocked mode: trailing half pending.
    logic line;                     // Level on the transmit or clock pin.
    logic line_oe;                  // Driver enable of that pin.
    logic dt;                       // Level on the data pin.
    logic dt_oe;                    // Driver enable of the data pin.
    logic rx_s1;                    // Receive pin first sync stage.
    logic rx_s2;                    // Receive pin second sync stage.
    logic rx_prev;                  // Previous synchronised level.
    ubh_seq_t rx_st;                // Receive sequencer state.
    logic [15:0] rx_cnt;            // Receive bit timer.
    logic [3:0] rx_bit;             // Receive bit index.
    logic [7:0] rx_shift;           // Receive shift register.
    logic [7:0] rx_data;            // Receive data register.
    logic rx_done;                  // Receive complete flag.
    logic framing_error_flag;                     // Framing error flag.
  } ubh_state_t;

  ubh_state_t state_reg;
  ubh_state_t state_next;

  // True when a bit timer has reached the end of its period.
  function automatic logic timer_done(input logic [15:0] cnt,
                                      input logic [15:0] limit);
    timer_done = (cnt == limit);
  endfunction

  // Advances a bit timer, wrapping to zero at its limit.
  function automatic logic [15:0] timer_step(input logic [15:0] cnt,
                                             input logic [15:0] limit);
    timer_step = (cnt == limit) ? 16'h0000 : cnt + 16'h0001;
  endfunction

  // Decoded configuration from the control register, then bus strobes, pin edges and timer ticks.
  logic serial_port_enable;
  logic transmit_enable;
  logic sync_md;
  logic host;
  logic rx_en;
  logic pol;
  logic host_tx;
  logic tx_ok;
  logic acc;
  logic wr;
  logic rd;
  logic rx_fall;
  logic rx_rise;
  logic tx_tick;
  logic rx_tick;
  logic hw_clr_break_send_request;

  // Next-state logic for the bus slave, transmitter and receiver.
  always_comb begin
    state_next = state_reg;
    serial_port_enable = state_reg.ctrl[UBH_CTRL_SERIAL_PORT_ENABLE];
    transmit_enable = state_reg.ctrl[UBH_CTRL_TRANSMIT_ENABLE];
    sync_md = state_reg.ctrl[UBH_CTRL_SYNC];
    host = state_reg.ctrl[UBH_CTRL_HOST];
    rx_en = state_reg.ctrl[UBH_CTRL_SINGLE_RECEIVE_ENABLE] | state_reg.ctrl[UBH_CTRL_CONTINUOUS_RECEIVE_ENABLE];
    pol = state_reg.ctrl[UBH_CTRL_POL];
    // Clocked host transmits only while both receive enables are clear.
    host_tx = serial_port_enable & sync_md & host & ~rx_en;
    // Transfers into the shifter need the port enabled, in a usable mode.
    tx_ok = serial_port_enable & transmit_enable & (~sync_md | host_tx);
    // A request completes in the cycle that waitrequest is low.
    acc = (i_read | i_write) & ~state_reg.wait_rq;
    wr = acc & i_write;
    rd = acc & i_read;
    rx_fall = state_reg.rx_prev & ~state_reg.rx_s2;
    rx_rise = ~state_reg.rx_prev & state_reg.rx_s2;
    tx_tick = timer_done(state_reg.tx_cnt, state_reg.baud);
    rx_tick = timer_done(state_reg.rx_cnt, state_reg.baud);
    hw_clr_break_send_request = 1'b0;

    // Input synchroniser; only the second stage is looked at.
    state_next.rx_s1 = i_receive_or_data_pin;
    state_next.rx_s2 = state_reg.rx_s1;
    state_next.rx_prev = state_reg.rx_s2;

    // Waitrequest drops for one cycle after each new request.
    state_next.wait_rq = ~((i_read | i_write) & state_reg.wait_rq);
    if ((i_read | i_write) & state_reg.wait_rq) begin
      unique case (i_address)
        UBH_OFF_CTRL: state_next.rdata = {22'h0, state_reg.ctrl};
        UBH_OFF_STATUS: begin
          state_next.rdata = 32'h00000000;
          state_next.rdata[UBH_ST_SHIFT_EMPTY] =
            (state_reg.tx_st == UBH_IDLE);
          state_next.rdata[UBH_ST_BUF_EMPTY] = ~state_reg.buf_full;
          state_next.rdata[UBH_ST_RX_DONE] = state_reg.rx_done;
          state_next.rdata[UBH_ST_FRAME_ERR] = state_reg.framing_error_flag;
        end
        // The transmit data register and shifter read back as zero.
        UBH_OFF_RXDATA: state_next.rdata = {24'h000000, state_reg.rx_data};
        UBH_OFF_BAUD: state_next.rdata = {16'h0000, state_reg.baud};
        default: state_next.rdata = 32'h00000000;
      endcase
    end

    // Register writes; unmapped offsets are ignored.
    if (wr) begin
      if (i_address == UBH_OFF_CTRL) begin
        if (i_byteenable[0]) begin
          state_next.ctrl[7:0] = i_writedata[7:0];
        end
        if (i_byteenable[1]) begin
          state_next.ctrl[9:8] = i_writedata[9:8];
        end
      end
      if (i_address == UBH_OFF_BAUD) begin
        if (i_byteenable[0]) begin
          state_next.baud[7:0] = i_writedata[7:0];
        end
        if (i_byteenable[1]) begin
          state_next.baud[15:8] = i_writedata[15:8];
        end
      end
      // A write fills the data register; it waits there while busy.
      if (i_address == UBH_OFF_TXDATA && i_byteenable[0]) begin
        state_next.buf_full = 1'b1;
        state_next.buf_data = i_writedata[7:0];
      end
    end

    // Transmit sequencer.
    state_next.tx_cnt = timer_step(state_reg.tx_cnt, state_reg.baud);
    unique case (state_reg.tx_st)
      UBH_IDLE: begin
        state_next.tx_cnt = 16'h0000;
        if (state_reg.buf_full & tx_ok) begin
          // Move to the shifter at once; the data register empties.
          state_next.buf_full = 1'b0;
          // The break request is sampled only here.
          state_next.tx_brk = state_reg.ctrl[UBH_CTRL_BREAK_SEND_REQUEST] & ~sync_md;
          if (state_reg.ctrl[UBH_CTRL_BREAK_SEND_REQUEST] & ~sync_md) begin
            // Break ignores the written value and sends twelve zeros.
            state_next.shift = 8'h00;
            state_next.tx_last = UBH_LAST_BREAK_BIT;
          end else begin
            state_next.shift = state_reg.buf_data;
            state_next.tx_last = UBH_LAST_DATA_BIT;
          end
          state_next.tx_bit = 4'h0;
          if (sync_md) begin
            // No start bit; leading clock edge and first bit come together.
            state_next.tx_st = UBH_DATA;
            state_next.line = ~pol;
            state_next.dt = state_reg.buf_data[0];
            state_next.phase = 1'b1;
          end else begin
            state_next.tx_st = UBH_START;
            state_next.line = 1'b0;
          end
        end
      end
      UBH_START: begin
        if (tx_tick) begin
          state_next.tx_st = UBH_DATA;
          state_next.line = state_reg.shift[0];
        end
      end
      UBH_DATA: begin
        if (tx_tick) begin
          if (sync_md) begin
            if (state_reg.phase) begin
              // Trailing edge: clock back to idle, data held.
              state_next.line = pol;
              state_next.phase = 1'b0;
              state_next.shift = {1'b0, state_reg.shift[7:1]};
              state_next.tx_bit = state_reg.tx_bit + 4'h1;
              // One clock per bit and no more.
              if (state_reg.tx_bit == state_reg.tx_last) begin
                state_next.tx_st = UBH_IDLE;
              end
            end else begin
              // Leading edge: clock active and the next bit presented.
              state_next.line = ~pol;
              state_next.dt = state_reg.shift[0];
              state_next.phase = 1'b1;
            end
          end else begin
            state_next.shift = {1'b0, state_reg.shift[7:1]};
            state_next.tx_bit = state_reg.tx_bit + 4'h1;
            if (state_reg.tx_bit == state_reg.tx_last) begin
              state_next.tx_st = UBH_STOP;
              state_next.line = 1'b1;
            end else begin
              state_next.line = state_reg.shift[1];
            end
          end
        end
      end
      UBH_STOP: begin
        if (tx_tick) begin
          state_next.tx_st = UBH_IDLE;
          hw_clr_break_send_request = state_reg.tx_brk;
        end
      end
    endcase

    // Hardware clear of the break request; a software set the same cycle wins.
    if (hw_clr_break_send_request & ~(wr & i_address == UBH_OFF_CTRL & i_byteenable[0] &
        i_writedata[UBH_CTRL_BREAK_SEND_REQUEST])) begin
      state_next.ctrl[UBH_CTRL_BREAK_SEND_REQUEST] = 1'b0;
    end

    // Pin drivers: the clock pin is driven in clocked host mode, the data
    // pin only while transmitting, never both directions at once.
    state_next.line_oe = serial_port_enable & (sync_md ? host : transmit_enable);
    state_next.dt_oe = host_tx;
    if (~serial_port_enable | (sync_md & ~host_tx)) begin
      // Leaving transmit abandons the character; clock returns to idle.
      state_next.tx_st = UBH_IDLE;
      state_next.line = sync_md ? pol : 1'b1;
    end else if (state_reg.tx_st == UBH_IDLE &
                 ~(state_reg.buf_full & tx_ok)) begin
      // An idle shift clock rests at the level the polarity bit selects.
      state_next.line = sync_md ? pol : 1'b1;
    end

    // Receive data read clears the flags; a new event the same cycle wins.
    if (rd & i_address == UBH_OFF_RXDATA) begin
      state_next.rx_done = 1'b0;
      state_next.framing_error_flag = 1'b0;
    end

    // Asynchronous receiver, or wake-on-break watcher.
    state_next.rx_cnt = timer_step(state_reg.rx_cnt, state_reg.baud);
    if (~serial_port_enable | sync_md) begin
      state_next.rx_st = UBH_IDLE;
    end else if (state_reg.ctrl[UBH_CTRL_WAKE]) begin
      state_next.rx_st = UBH_IDLE;
      // Falling line is the wake event and raises the receive flag.
      if (rx_fall) begin
        state_next.rx_done = 1'b1;
      end
      // Rising line ends the Break; the wake-on-break enable clears.
      if (rx_rise & ~(wr & i_address == UBH_OFF_CTRL & i_byteenable[1] &
          i_writedata[UBH_CTRL_WAKE])) begin
        state_next.ctrl[UBH_CTRL_WAKE] = 1'b0;
      end
    end else begin
      unique case (state_reg.rx_st)
        UBH_IDLE: begin
          if (rx_fall) begin
            // Wait half a bit to land in the middle of the start bit.
            state_next.rx_st = UBH_START;
            state_next.rx_cnt = {1'b0, state_reg.baud[15:1]};
          end
        end
        UBH_START: begin
          if (rx_tick) begin
            state_next.rx_st = state_reg.rx_s2 ? UBH_IDLE : UBH_DATA;
            state_next.rx_bit = 4'h0;
          end
        end
        UBH_DATA: begin
          if (rx_tick) begin
            state_next.rx_shift = {state_reg.rx_s2, state_reg.rx_shift[7:1]};
            state_next.rx_bit = state_reg.rx_bit + 4'h1;
            if (state_reg.rx_bit == UBH_LAST_DATA_BIT) begin
              state_next.rx_st = UBH_STOP;
            end
          end
        end
        UBH_STOP: begin
          if (rx_tick) begin
            // A low stop bit is a framing error; a Break reads 00h.
            state_next.rx_st = UBH_IDLE;
            state_next.rx_data = state_reg.rx_shift;
            state_next.rx_done = 1'b1;
            state_next.framing_error_flag = ~state_reg.rx_s2;
          end
        end
      endcase
    end
  end

  // Single state register with constant reset values.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= '0;
      state_reg.wait_rq <= 1'b1;
      state_reg.ctrl <= UBH_CTRL_RESET;
      state_reg.baud <= UBH_BAUD_RESET;
      state_reg.tx_st <= UBH_IDLE;
      state_reg.rx_st <= UBH_IDLE;
      state_reg.line <= 1'b1;
      state_reg.rx_s1 <= 1'b1;
      state_reg.rx_s2 <= 1'b1;
      state_reg.rx_prev <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from the state register.
  assign o_readdata = state_reg.rdata;
  assign o_waitrequest = state_reg.wait_rq;
  assign o_receive_or_data_pin = state_reg.dt;
  assign o_receive_or_data_pin_oe = state_reg.dt_oe;
  assign o_transmit_or_clock_pin = state_reg.line;
  assign o_transmit_or_clock_pin_oe = state_reg.line_oe;

endmodule
`default_nettype wire

//--- tb/testbench.sv
// Purpose: Self-checking run over the register bus and the serial line.
// Assumes: Divisor 7 gives eight clocks, 800 ns, per bit.
// Notes: Expected values queue up; watcher processes compare them.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ubh_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [4:0] i_address = 5'h00;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic [31:0] o_readdata, q, rd_got, re;
  logic o_waitrequest, dt_o, dt_oe, ck_o, ck_oe, got, prt_rx;
  logic [8:0] got_val, le;
  logic [7:0] r;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [8:0] ln_q[$]; // Expected characters seen by the partner.
  logic [31:0] rd_q[$]; // Expected masked read data.
  event rd_ev;
  // The design wins the data wire while it drives; clock pin pulled up.
  wire logic rx_w = dt_oe ? dt_o : prt_rx;
  wire logic ck_w = ck_oe ? ck_o : 1'b1;
  ubh_serial i_ubh_serial (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .i_byteenable(4'hf), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_receive_or_data_pin(rx_w),
    .o_receive_or_data_pin(dt_o), .o_receive_or_data_pin_oe(dt_oe),
    .o_transmit_or_clock_pin(ck_o), .o_transmit_or_clock_pin_oe(ck_oe));
  ubh_partner i_ubh_partner (.i_line(ck_w), .i_data(rx_w), .o_rx(prt_rx),
    .o_got(got), .o_val(got_val));
  always #50 i_clk = ~i_clk;
  task automatic stop_test();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic bad(input logic [31:0] g, input logic [31:0] e);
    error_cnt++;
    $display("BAD t=%0t got=%h exp=%h", $time, g, e);
  endtask
  // One bus transfer; the request holds until the rising edge that sees
  // waitrequest low, where read data is taken and the request released.
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] v);
    int n = 0;
    @(posedge i_clk);
    i_read <= !w;
    i_write <= w;
    i_address <= a;
    i_writedata <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 40);
    v = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
    if (n >= 40) begin
      error_cnt++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] m, e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0, q);
    rd_got = q & m;
    -> rd_ev;
  endtask
  // Poll one bit until it reads v, with a bound.
  task automatic poll(input logic [4:0] a, input int b, input logic v);
    int n = 0;
    do begin
      bus(1'b0, a, 32'h0, q);
      n++;
    end while (q[b] !== v && n < 500);
    if (n >= 500) begin
      error_cnt++;
      stop_test();
    end
  endtask
  task automatic drain();
    int n = 0;
    while (ln_q.size() != 0 && n < 3000) begin
      @(posedge i_clk);
      n++;
    end
    if (ln_q.size() != 0) begin
      error_cnt++;
      stop_test();
    end
  endtask
  always @(rd_ev) begin
    samples_checked++;
    re = rd_q.pop_front();
    if (rd_got !== re) bad(rd_got, re);
  end
  always @(posedge got) begin
    samples_checked++;
    le = (ln_q.size() != 0) ? ln_q.pop_front() : 9'h1ff;
    if (got_val !== le) bad({23'h0, got_val}, {23'h0, le});
  end
  initial begin
    #9000000;
    error_cnt++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h9238));
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rchk(UBH_OFF_CTRL, 32'h3ff, 32'h0);
    rchk(UBH_OFF_BAUD, 32'hffff, 32'h40);
    rchk(UBH_OFF_STATUS, 32'hf, 32'h3);
    rchk(UBH_OFF_TXDATA, 32'hffffffff, 32'h0);
    wr(5'h14, 32'h3);
    rchk(5'h14, 32'hffffffff, 32'h0);
    rchk(UBH_OFF_CTRL, 32'h3ff, 32'h0);
    wr(UBH_OFF_BAUD, 32'h7);
    r = $urandom;
    wr(UBH_OFF_CTRL, 32'h3);
    ln_q.push_back({1'b0, r});
    wr(UBH_OFF_TXDATA, {24'h0, r});
    drain();
    // LIN header: Break started by a nonzero dummy, then the sync byte.
    r = $urandom | 8'h01;
    wr(UBH_OFF_CTRL, 32'h7);
    ln_q.push_back(9'h10c);
    ln_q.push_back(9'h055);
    wr(UBH_OFF_TXDATA, {24'h0, r});
    poll(UBH_OFF_STATUS, 1, 1'b1);
    wr(UBH_OFF_TXDATA, 32'h55);
    rchk(UBH_OFF_STATUS, 32'h3, 32'h0);
    rchk(UBH_OFF_CTRL, 32'h7, 32'h7);
    drain();
    poll(UBH_OFF_STATUS, 0, 1'b1);
    rchk(UBH_OFF_CTRL, 32'h7, 32'h3);
    wr(UBH_OFF_CTRL, 32'h43);
    i_ubh_partner.send(9'h100);
    poll(UBH_OFF_STATUS, 2, 1'b1);
    rchk(UBH_OFF_STATUS, 32'hc, 32'hc);
    rchk(UBH_OFF_RXDATA, 32'hff, 32'h0);
    rchk(UBH_OFF_STATUS, 32'hc, 32'h0);
    // Wake on Break, auto-baud requested alongside, then one data byte.
    wr(UBH_OFF_CTRL, 32'h343);
    fork
      i_ubh_partner.send(9'h100);
    join_none
    poll(UBH_OFF_STATUS, 2, 1'b1);
    rchk(UBH_OFF_CTRL, 32'h100, 32'h100);
    poll(UBH_OFF_CTRL, 8, 1'b0);
    wait fork;
    bus(1'b0, UBH_OFF_RXDATA, 32'h0, q);
    r = $urandom;
    i_ubh_partner.send({1'b0, r});
    poll(UBH_OFF_STATUS, 2, 1'b1);
    rchk(UBH_OFF_RXDATA, 32'hff, {24'h0, r});
    rchk(UBH_OFF_STATUS, 32'h8, 32'h0);
    // Clocked host transmit, idle-high clock first, then idle-low.
    i_ubh_partner.mode(1'b1, 1'b1);
    wr(UBH_OFF_CTRL, 32'h9b);
    for (int p = 0; p < 2; p++) begin
      repeat (2) begin
        r = $urandom;
        ln_q.push_back({1'b0, r});
        wr(UBH_OFF_TXDATA, {24'h0, r});
      end
      rchk(UBH_OFF_STATUS, 32'h3, 32'h0);
      drain();
      poll(UBH_OFF_STATUS, 0, 1'b1);
      wr(UBH_OFF_CTRL, 32'h1b);
      // The clock moves to its new idle level first; that is no bit.
      repeat (2) @(posedge i_clk);
      i_ubh_partner.mode(1'b1, 1'b0);
    end
    wr(UBH_OFF_CTRL, 32'h3b);
    repeat (4) @(posedge i_clk);
    stop_test();
  end
endmodule
`default_nettype wire

//--- tb/ubh_partner.sv
// Purpose: Far-side node: decodes the line or shift clock, sends frames.
// Assumes: Bit time of 800 ns with its own phase.
// Notes: Break is reported as 9'h100 plus the count of zero bits.
`timescale 1ns/1ps
`default_nettype none
module ubh_partner #(
  parameter int BIT_NS = 800
) (
  input wire logic i_line,
  input wire logic i_data,
  output var logic o_rx,
  output var logic o_got,
  output var logic [8:0] o_val
);
  logic clocked = 1'b0; // Listen to the shift clock, not the line.
  logic pol = 1'b0; // Idle level of the shift clock.
  logic [7:0] sh, cs; // Async and clocked assembly.
  int lows, nb = 0;
  initial begin
    o_rx = 1'b1;
    o_got = 1'b0;
    o_val = 9'h000;
  end
  // Mode is set while the shift clock rests, so its moves are not taken as bits.
  task automatic mode(input logic c, input logic p);
    clocked = c;
    pol = p;
    nb = 0;
  endtask
  // Start, eight data or twelve zeros, then high; idles high afterwards.
  task automatic send(input logic [8:0] v);
    #37 o_rx = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 12; i++) begin
      o_rx = v[8] ? 1'b0 : (i < 8 ? v[i] : 1'b1);
      #(BIT_NS);
    end
    o_rx = 1'b1;
    #(2 * BIT_NS);
  endtask
  // Async: sample mid-bit; a low stop bit keeps counting zeros.
  always @(negedge i_line) if (!clocked) begin
    #(BIT_NS / 2);
    for (int i = 0; i < 8; i++) begin
      #(BIT_NS);
      sh[i] = i_line;
    end
    lows = 0;
    #(BIT_NS);
    while (!i_line && lows < 15) begin
      lows++;
      #(BIT_NS);
    end
    o_val = (lows == 0) ? {1'b0, sh} : 9'h108 + 9'(lows);
    o_got = 1'b1;
    #1 o_got = 1'b0;
  end
  // Clocked: data is taken when the clock returns to its idle level.
  always @(i_line) if (clocked && i_line == pol) begin
    cs[nb] = i_data;
    nb++;
    if (nb == 8) begin
      nb = 0;
      o_val = {1'b0, cs};
      o_got = 1'b1;
      #1 o_got = 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- tb/ubh_properties.sv
// Purpose: Port-level checks of the serial port with Break and host clock.
// Assumes: Control and divisor views are rebuilt from completed writes.
// Notes: The pacing check only applies with a divisor of 7 (8 clocks a clock phase).
`timescale 1ns/1ps
`default_nettype none
module ubh_properties
  import ubh_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic i_receive_or_data_pin,
  input wire logic o_receive_or_data_pin,
  input wire logic o_receive_or_data_pin_oe,
  input wire logic o_transmit_or_clock_pin,
  input wire logic o_transmit_or_clock_pin_oe
);
  logic [9:0] ctrl_reg; // Software-written control bits.
  logic [15:0] baud_reg; // Software-written divisor.
  logic [7:0] low_reg; // Clocks the line has been low, saturating.
  logic dt_on, ck_on, async_on, ck, dt, unmapped;
  // Hardware-cleared bits are not needed here, so a write shadow suffices.
  assign dt_on = &{ctrl_reg[0], ctrl_reg[3], ctrl_reg[4], ~ctrl_reg[6:5]};
  assign ck_on = ctrl_reg[0] & (ctrl_reg[3] ? ctrl_reg[4] : ctrl_reg[1]);
  assign async_on = ctrl_reg[0] & ~ctrl_reg[3] & ctrl_reg[1];
  assign ck = o_transmit_or_clock_pin;
  assign dt = o_receive_or_data_pin;
  assign unmapped = i_address[1:0] != 2'h0 || i_address > UBH_OFF_BAUD;
  // One process keeps the shadows and the low-time counter.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_reg <= UBH_CTRL_RESET;
      baud_reg <= UBH_BAUD_RESET;
      low_reg <= 8'h00;
    end else begin
      if (i_write && !o_waitrequest && i_address == UBH_OFF_CTRL) begin
        ctrl_reg <= i_writedata[9:0];
      end
      if (i_write && !o_waitrequest && i_address == UBH_OFF_BAUD) begin
        baud_reg <= i_writedata[15:0];
      end
      low_reg <= ck ? 8'h00 : low_reg + {7'h00, low_reg != 8'hff};
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  property p_wait;
    $rose(i_read || i_write) |=> !o_waitrequest ##1 o_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer not in one wait");
  property p_dt_oe;
    $stable(dt_on) |-> o_receive_or_data_pin_oe == dt_on;
  endproperty
  a_dt_oe: assert property (p_dt_oe) else $error("data driver wrong");
  property p_ck_oe;
    $stable(ck_on) |-> o_transmit_or_clock_pin_oe == ck_on;
  endproperty
  a_ck_oe: assert property (p_ck_oe) else $error("clock driver wrong");
  property p_dt_edge;
    dt_on && $stable(ctrl_reg) && $changed(dt) |-> ck != ctrl_reg[7] && $changed(ck);
  endproperty
  a_dt_edge: assert property (p_dt_edge) else $error("data off lead edge");
  property p_ck_pace;
    dt_on && baud_reg == 16'h0007 && $changed(ck) && ck != ctrl_reg[7]
      |=> $stable(ck)[*7] ##1 $changed(ck);
  endproperty
  a_ck_pace: assert property (p_ck_pace) else $error("clock phase length");
  property p_low_run;
    async_on && $rose(ck) |-> low_reg[2:0] == 3'h0 && low_reg <= 8'h68;
  endproperty
  a_low_run: assert property (p_low_run) else $error("low time not bits");
  property p_stop;
    async_on && $rose(ck) |=> ck [*7];
  endproperty
  a_stop: assert property (p_stop) else $error("stop bit too short");
  property p_hidden;
    i_read && !o_waitrequest && (unmapped || i_address == UBH_OFF_TXDATA)
      |-> o_readdata == 32'h0;
  endproperty
  a_hidden: assert property (p_hidden) else $error("hidden place readable");
  c_break: cover property (async_on && $rose(ck) && low_reg == 8'h68);
  c_clk: cover property (dt_on && $changed(ck));
  c_hidden: cover property (i_read && !o_waitrequest && unmapped);
endmodule
bind ubh_serial ubh_properties i_ubh_properties (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_address(i_address),
  .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
  .i_byteenable(i_byteenable), .o_readdata(o_readdata),
  .o_waitrequest(o_waitrequest),
  .i_receive_or_data_pin(i_receive_or_data_pin),
  .o_receive_or_data_pin(o_receive_or_data_pin),
  .o_receive_or_data_pin_oe(o_receive_or_data_pin_oe),
  .o_transmit_or_clock_pin(o_transmit_or_clock_pin),
  .o_transmit_or_clock_pin_oe(o_transmit_or_clock_pin_oe)
);
`default_nettype wire
